// ---- design/isw_params.svh ----
// constants for the identification and status word and its serial frame
`ifndef ISW_PARAMS_SVH
`define ISW_PARAMS_SVH
`define ISW_FRAME_BITS 32
`define ISW_RW_BIT 31
`define ISW_ADDR_HI 30
`define ISW_ADDR_LO 24
`define ISW_ADDR_VALUE 7'h00
`define ISW_MAKER_HI 23
`define ISW_MAKER_LO 16
`define ISW_VERSION_HI 15
`define ISW_VERSION_LO 8
`define ISW_WDOG_BIT 1
`define ISW_WDOG_RESET 1'b0
`endif

// ---- design/isw_pkg.sv ----
// types for the identification and status word block
package isw_pkg;
    typedef enum logic [1:0] {
        ISW_IDLE  = 2'b01,
        ISW_SHIFT = 2'b10
    } isw_state_t;
endpackage

// ---- design/isw_ident_status.sv ----
// serial-facing identification and status word with clock-watchdog flag
`timescale 1ns/100ps
`include "isw_params.svh"

// ****************************************
// identification and status word
// ****************************************
// How it works
// - frames addressing this word are reads whatever bit 31 says; content never written
// - bit 31 of the returned word always reads 0
// - watchdog timeout while the watchdog is enabled sets bit 1; only reset clears it
// - bit 1 reads 0 after reset until a timeout arrives while the watchdog is enabled
// - 32-bit frames, both directions shifted most significant bit first
// - the frame after an invalid frame is answered with this word
// - first frame after reset returns this word whatever the command
module isw_ident_status #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,   // arbitrary value
    parameter logic [7:0] VERSION_CODE = 8'h01, // arbitrary value
    parameter int FRAME_BITS = `ISW_FRAME_BITS
) (
    input wire logic clk_sys_in,          // system clock, 100 MHz
    input wire logic rst_in,              // async reset, active high
    input wire logic frame_sel_n_in,      // chip select, low during a frame
    input wire logic sclk_rise_in,        // one-cycle pulse: sample serial input
    input wire logic sclk_fall_in,        // one-cycle pulse: advance serial output
    input wire logic serial_data_in,      // host to device data
    input wire logic wdog_timeout_in,     // pulse or level: clock watchdog expired
    input wire logic wdog_enable_in,      // clock watchdog enabled
    input wire logic other_word_valid_in, // other register bank claims the frame
    input wire logic [31:0] other_word_in, // answer from other registers
    output logic serial_data_out,         // device to host data, from flip-flop
    output logic frame_done_out,          // one-cycle pulse at frame end
    output logic frame_invalid_out,       // last frame judged invalid
    output logic [31:0] ident_word_out    // current identification word
);

    // the shift registers and the address field are laid out for 32-bit frames only
    if (FRAME_BITS != `ISW_FRAME_BITS) begin : g_bad_frame_bits
        $error("isw_ident_status: frame length must be 32");
    end

    // ****************************************
    // watchdog status flag
    // ****************************************
    logic clock_watchdog_timeout_flag_q;
    logic clock_watchdog_timeout_flag_d;

    always_comb begin
        clock_watchdog_timeout_flag_d = clock_watchdog_timeout_flag_q;
        // sticky: nothing but reset clears it
        if (wdog_timeout_in && wdog_enable_in) begin
            clock_watchdog_timeout_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            clock_watchdog_timeout_flag_q <= `ISW_WDOG_RESET;
        end else begin
            clock_watchdog_timeout_flag_q <= clock_watchdog_timeout_flag_d;
        end
    end

    // ****************************************
    // identification word
    // ****************************************
    logic [31:0] identification_status_word;
    always_comb begin
        identification_status_word = 32'h0000_0000;
        identification_status_word[`ISW_RW_BIT] = 1'b0;
        identification_status_word[`ISW_MAKER_HI:`ISW_MAKER_LO] = MAKER_CODE;
        identification_status_word[`ISW_VERSION_HI:`ISW_VERSION_LO] = VERSION_CODE;
        identification_status_word[`ISW_WDOG_BIT] = clock_watchdog_timeout_flag_q;
    end

    // ****************************************
    // frame engine
    // ****************************************
    isw_pkg::isw_state_t state_q;
    isw_pkg::isw_state_t state_d;
    logic [31:0] rx_q;
    logic [31:0] rx_d;
    logic [31:0] tx_q;
    logic [31:0] tx_d;
    logic [5:0] count_q;
    logic [5:0] count_d;
    logic first_q;
    logic first_d;
    logic invalid_q;
    logic invalid_d;
    logic done_q;
    logic done_d;
    logic [31:0] reply_word;
    logic addr_hit;
    logic in_frame;
    logic frame_start;
    logic frame_end;
    logic count_ok;

    // the answer for the next frame is picked from the frame just ended
    always_comb begin
        addr_hit = (rx_q[`ISW_ADDR_HI:`ISW_ADDR_LO] == `ISW_ADDR_VALUE);
        if (first_q || addr_hit || !other_word_valid_in) begin
            reply_word = identification_status_word;
        end else begin
            reply_word = other_word_in;
        end
    end

    // ****************************************
    // frame sequencing
    // ****************************************
    assign in_frame = (state_q == isw_pkg::ISW_SHIFT);
    assign count_ok = (count_q == 6'(FRAME_BITS));

    always_comb begin
        state_d = state_q;
        first_d = first_q;
        invalid_d = invalid_q;
        done_d = 1'b0;
        frame_start = 1'b0;
        frame_end = 1'b0;
        unique case (state_q)
            isw_pkg::ISW_IDLE: begin
                if (!frame_sel_n_in) begin
                    state_d = isw_pkg::ISW_SHIFT;
                    frame_start = 1'b1;
                end
            end
            isw_pkg::ISW_SHIFT: begin
                if (frame_sel_n_in) begin
                    state_d = isw_pkg::ISW_IDLE;
                    frame_end = 1'b1;
                    done_d = 1'b1;
                    first_d = 1'b0;
                    // a short or long frame is invalid; the word stays unwritten
                    invalid_d = !count_ok;
                end
            end
            default: begin
                // an illegal code is left at once; no frame is assumed in progress
                state_d = isw_pkg::ISW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= isw_pkg::ISW_IDLE;
            first_q <= 1'b1;
            invalid_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            first_q <= first_d;
            invalid_q <= invalid_d;
            done_q <= done_d;
        end
    end

    // ****************************************
    // bit counter
    // ****************************************
    always_comb begin
        count_d = count_q;
        if (frame_start) begin
            count_d = 6'h00;
        end else if (in_frame && sclk_rise_in && (count_q != 6'h3f)) begin
            // saturates so that a very long frame cannot wrap back to a valid count
            count_d = count_q + 6'h01;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= 6'h00;
        end else begin
            count_q <= count_d;
        end
    end

    // ****************************************
    // receive shifter
    // ****************************************
    always_comb begin
        rx_d = rx_q;
        if (in_frame && sclk_rise_in) begin
            rx_d = {rx_q[30:0], serial_data_in};
        end
        // a cut frame leaves no address behind, so the next reply is this word
        if (frame_end && !count_ok) begin
            rx_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rx_q <= 32'h0000_0000;
        end else begin
            rx_q <= rx_d;
        end
    end

    // ****************************************
    // transmit shifter
    // ****************************************
    always_comb begin
        tx_d = tx_q;
        if (frame_start) begin
            tx_d = reply_word;
        end else if (in_frame && sclk_fall_in) begin
            tx_d = {tx_q[30:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tx_q <= 32'h0000_0000;
        end else begin
            tx_q <= tx_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign serial_data_out = tx_q[31];
    assign frame_done_out = done_q;
    assign frame_invalid_out = invalid_q;
    assign ident_word_out = identification_status_word;

endmodule // isw_ident_status

// ---- dv/isw_host_model.sv ----
// host side model: drives one serial frame at a time
`timescale 1ns/100ps
module isw_host_model (
    input wire logic clk_in,    // system clock
    input wire logic sdo_in,    // device reply bit
    output logic sel_n_out = 1'b1, // frame select, low in frame
    output logic rise_out = 1'b0,  // sample pulse
    output logic fall_out = 1'b0,  // shift pulse
    output logic sdi_out = 1'b0    // host data
);
    // n below 32 makes a short, invalid frame
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        @(negedge clk_in) sel_n_out = 1'b0;
        @(negedge clk_in);
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                fall_out = 1'b1;
                @(negedge clk_in) fall_out = 1'b0;
            end
            sdi_out = tx[31-i];
            rise_out = 1'b1;
            rx = {rx[30:0], sdo_in};
            @(negedge clk_in) rise_out = 1'b0;
        end
        sel_n_out = 1'b1;
        sdi_out = ~sdi_out; // released line must not keep its value
        repeat (3) @(negedge clk_in);
    endtask
endmodule // isw_host_model

// ---- dv/isw_ident_status_chk.sv ----
// assertions on the identification word block ports
`timescale 1ns/100ps
module isw_ident_status_chk #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,  // must follow the design
    parameter logic [7:0] VERSION_CODE = 8'h01 // must follow the design
) (
    input wire logic clk_sys_in,           // system clock
    input wire logic rst_in,               // async reset, active high
    input wire logic frame_sel_n_in,       // frame select, low in frame
    input wire logic sclk_rise_in,         // sample pulse
    input wire logic wdog_timeout_in,      // watchdog expired
    input wire logic wdog_enable_in,       // watchdog enabled
    input wire logic serial_data_out,      // device reply bit
    input wire logic frame_done_out,       // frame end pulse
    input wire logic frame_invalid_out,    // last frame invalid
    input wire logic [31:0] ident_word_out // current word
);
    logic [5:0] cnt_q;
    logic first_q;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
            first_q <= 1'b1;
        end else begin
            cnt_q <= frame_done_out ? 6'h00 : cnt_q + 6'(sclk_rise_in && !frame_sel_n_in);
            first_q <= first_q && !frame_done_out;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    rw_zero_a: assert property (!ident_word_out[31])
        else $error("rw bit");
    code_fields_a: assert property (
        ident_word_out[23:8] == {MAKER_CODE, VERSION_CODE})
        else $error("codes");
    word_fixed_a: assert property (
        frame_done_out |-> ident_word_out[31:2] == {8'h00, MAKER_CODE, VERSION_CODE, 6'h00})
        else $error("word changed");
    flag_set_a: assert property (
        wdog_enable_in && wdog_timeout_in |-> ##[1:2] ident_word_out[1])
        else $error("flag not set");
    flag_hold_a: assert property (ident_word_out[1] |=> ident_word_out[1])
        else $error("flag cleared");
    flag_quiet_a: assert property (
        !ident_word_out[1] && !(wdog_enable_in && wdog_timeout_in)
        && !$past(wdog_enable_in && wdog_timeout_in) |=> !ident_word_out[1])
        else $error("flag rose");
    frame_len_a: assert property (
        frame_done_out |-> frame_invalid_out == (cnt_q != 6'h20))
        else $error("length");
    first_reply_a: assert property (
        first_q && $fell(frame_sel_n_in) |=> !serial_data_out)
        else $error("first bit");
endmodule // isw_ident_status_chk

// ---- dv/tb_isw_ident_status.sv ----
// self-checking bench for the identification and status word
`timescale 1ns/100ps
module tb_isw_ident_status;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, wdog_timeout_in = 1'b0, wdog_enable_in = 1'b0;
    logic frame_sel_n_in, sclk_rise_in, sclk_fall_in, serial_data_in, serial_data_out;
    logic frame_done_out, frame_invalid_out;
    logic [31:0] ident_word_out, rx;
    int errors = 0, n_checks = 0;
    localparam logic [31:0] ID = 32'h005a_0100;
    initial forever #5 clk_sys_in = ~clk_sys_in;
    isw_host_model u_host (.clk_in(clk_sys_in), .sdo_in(serial_data_out),
        .sel_n_out(frame_sel_n_in), .rise_out(sclk_rise_in), .fall_out(sclk_fall_in),
        .sdi_out(serial_data_in));
    isw_ident_status u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .frame_sel_n_in(frame_sel_n_in), .sclk_rise_in(sclk_rise_in),
        .sclk_fall_in(sclk_fall_in), .serial_data_in(serial_data_in),
        .wdog_timeout_in(wdog_timeout_in), .wdog_enable_in(wdog_enable_in),
        .other_word_valid_in(1'b1), .other_word_in(32'h8123_4567),
        .serial_data_out(serial_data_out), .frame_done_out(frame_done_out),
        .frame_invalid_out(frame_invalid_out), .ident_word_out(ident_word_out));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys_in);
        rst_in = 1'b0;
        u_host.xfer(32'h81ff_ffff, 32, rx);
        check(rx, ID);
        u_host.xfer(32'h80ff_ffff, 32, rx);
        // address 1 was asked for, so the other bank answers; an uneven word shows bit order
        check(rx, 32'h8123_4567);
        u_host.xfer(32'h0000_0000, 32, rx);
        check(rx, ID);
        check(32'(frame_invalid_out), 32'h0);
        // a cut frame that would leave address 1 behind
        u_host.xfer(32'h0200_0000, 31, rx);
        check(32'(frame_invalid_out), 32'h1);
        u_host.xfer(32'h0000_0000, 32, rx);
        check(rx, ID);
        check(32'(frame_invalid_out), 32'h0);
        wdog_timeout_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check(ident_word_out, ID);
        wdog_enable_in = 1'b1;
        @(negedge clk_sys_in) wdog_timeout_in = 1'b0;
        u_host.xfer(32'h0, 32, rx);
        check(rx, ID | 32'h2);
        wdog_enable_in = 1'b0;
        u_host.xfer(32'h0100_0000, 32, rx);
        check(rx, ID | 32'h2);
        rst_in = 1'b1;
        @(negedge clk_sys_in) rst_in = 1'b0;
        check(ident_word_out, ID);
        u_host.xfer(32'h0, 32, rx);
        check(rx, ID);
        finish_test;
    end
endmodule // tb_isw_ident_status
bind isw_ident_status isw_ident_status_chk #(.MAKER_CODE(MAKER_CODE),
    .VERSION_CODE(VERSION_CODE)) u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .frame_sel_n_in(frame_sel_n_in), .sclk_rise_in(sclk_rise_in),
    .wdog_timeout_in(wdog_timeout_in), .wdog_enable_in(wdog_enable_in),
    .serial_data_out(serial_data_out), .frame_done_out(frame_done_out),
    .frame_invalid_out(frame_invalid_out), .ident_word_out(ident_word_out));
